// File: hw/amd_pkg.sv
// address map constants, register table and region types for the map decoder
package amd_pkg;

    // ------------------------------------------------------------
    // address map
    // ------------------------------------------------------------
    localparam logic [15:0] HW_LAST   = 16'h007F;
    localparam logic [15:0] RAM_BASE  = 16'h0080;
    localparam logic [15:0] RAM_LAST  = 16'h01FF;
    localparam logic [15:0] STK_BASE  = 16'h0180;
    localparam logic [15:0] STK_LAST  = 16'h01FF;
    localparam logic [15:0] EEP_BASE  = 16'h1000;
    localparam logic [15:0] EEP_LAST  = 16'h10FF;
    localparam logic [15:0] FL_BASE   = 16'hE000;
    localparam logic [15:0] VEC_BASE  = 16'hFFE0;
    localparam logic [16:0] SPACE_TOP = 17'h10000;
    localparam logic [16:0] S0_MIN    = 17'h00200;
    localparam logic [1:0]  S0_CODE_RST = 2'h3;

    // ------------------------------------------------------------
    // register slots
    // ------------------------------------------------------------
    localparam int          NSLOT       = 16;
    localparam logic [6:0]  IDX_PA_DATA = 7'h00;
    localparam logic [6:0]  IDX_PA_DIR  = 7'h01;
    localparam logic [6:0]  IDX_PA_OPT  = 7'h02;
    localparam logic [6:0]  IDX_PB_DATA = 7'h03;
    localparam logic [6:0]  IDX_PB_DIR  = 7'h04;
    localparam logic [6:0]  IDX_PB_OPT  = 7'h05;
    localparam logic [6:0]  IDX_RSV0    = 7'h06;
    localparam logic [6:0]  IDX_RSV1    = 7'h07;
    localparam logic [6:0]  IDX_LT_CS2  = 7'h08;
    localparam logic [6:0]  IDX_LT_RLD  = 7'h09;
    localparam logic [6:0]  IDX_LT_CNT  = 7'h0A;
    localparam logic [6:0]  IDX_LT_CS1  = 7'h0B;
    localparam logic [6:0]  IDX_LT_CAP  = 7'h0C;
    localparam logic [15:0] HIT_MASK    = 16'h1F3F;
    localparam logic [15:0] RW_MASK     = 16'h0B3F;
    localparam logic [15:0][7:0] RST_TAB = {
        8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h00, 8'hFF, 8'h40, 8'h00, 8'hFF};

    // ------------------------------------------------------------
    // bus answers and region codes
    // ------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [2:0] {
        rg_none, rg_hw, rg_ram, rg_eep, rg_flash
    } amd_region_e;

endpackage : amd_pkg

// File: hw/amd_reg_if.sv
// write port and read view between the top and the register slots
`timescale 1ns/1ps
`default_nettype none
interface amd_reg_if;
    logic              wr;
    logic [6:0]        idx;
    logic [7:0]        wdata;
    logic [15:0][7:0]  view;
    modport master (output wr, output idx, output wdata, input view);
    modport slave  (input wr, input idx, input wdata, output view);
endinterface : amd_reg_if
`default_nettype wire

// File: hw/amd_regs.sv
// register slots: port and small timer registers with their reset values
`timescale 1ns/1ps
`default_nettype none
module amd_regs (
    input  wire logic       clk,
    input  wire logic       nrst,
    amd_reg_if.slave        rb,
    input  wire logic [7:0] tmr_count,
    input  wire logic [7:0] tmr_capture
);

    logic [15:0][7:0] view_w;

    // ------------------------------------------------------------
    // one slot per index
    // ------------------------------------------------------------
    for (genvar i = 0; i < amd_pkg::NSLOT; i++) begin : g_slot
        if (amd_pkg::RW_MASK[i]) begin : g_rw
            logic [7:0] val_q;
            // read-only and reserved slots never take a write
            always_ff @(posedge clk) begin
                if (!nrst) begin
                    val_q <= amd_pkg::RST_TAB[i];
                end else if (rb.wr && rb.idx == 7'(i)) begin
                    val_q <= rb.wdata;
                end
            end
            assign view_w[i] = val_q;
        end else if (i == 32'(amd_pkg::IDX_LT_CNT)) begin : g_cnt
            assign view_w[i] = tmr_count;
        end else if (i == 32'(amd_pkg::IDX_LT_CAP)) begin : g_cap
            assign view_w[i] = tmr_capture;
        end else begin : g_none
            assign view_w[i] = 8'h00;
        end
    end

    assign rb.view = view_w;

endmodule : amd_regs
`default_nettype wire

// File: hw/amd_decode.sv
// region decoder: one registered select per access, sector 0 and stack checks
`timescale 1ns/1ps
`default_nettype none
module amd_decode (
    input  wire logic        clk,
    input  wire logic        nrst,
    input  wire logic        valid,
    input  wire logic [15:0] addr,
    input  wire logic        stack,
    input  wire logic [1:0]  s0_code,
    output logic [3:0]       sel_q,
    output logic             s0_hit_q,
    output logic             vec_q,
    output logic             stk_fault_q,
    output logic [15:0]      s0_base_q
);

    amd_pkg::amd_region_e rg_d;
    logic                 stk_bad;
    logic [1:0]           s0_code_q;
    logic                 loaded_q;
    logic [16:0]          s0_size;

    // ------------------------------------------------------------
    // option capture
    // ------------------------------------------------------------
    // size code caught once after release, never while in reset
    always_ff @(posedge clk) begin
        if (!nrst) begin
            loaded_q  <= 1'b0;
            s0_code_q <= amd_pkg::S0_CODE_RST;
        end else if (!loaded_q) begin
            loaded_q  <= 1'b1;
            s0_code_q <= s0_code;
        end
    end

    assign s0_size = amd_pkg::S0_MIN << s0_code_q;

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s0_base_q <= 16'h0000;
        end else begin
            s0_base_q <= 16'(amd_pkg::SPACE_TOP - s0_size);
        end
    end

    // ------------------------------------------------------------
    // region decode
    // ------------------------------------------------------------
    // stack window check
    assign stk_bad = stack && (addr < amd_pkg::STK_BASE || addr > amd_pkg::STK_LAST);

    always_comb begin
        rg_d = amd_pkg::rg_none;
        if (stk_bad) begin
            rg_d = amd_pkg::rg_none;
        end else if (addr <= amd_pkg::HW_LAST) begin
            if (addr[6:0] != amd_pkg::IDX_RSV0 && addr[6:0] != amd_pkg::IDX_RSV1) begin
                rg_d = amd_pkg::rg_hw;
            end
        end else if (addr <= amd_pkg::RAM_LAST) begin
            rg_d = amd_pkg::rg_ram;
        end else if (addr >= amd_pkg::EEP_BASE && addr <= amd_pkg::EEP_LAST) begin
            rg_d = amd_pkg::rg_eep;
        end else if (addr >= amd_pkg::FL_BASE) begin
            rg_d = amd_pkg::rg_flash;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            sel_q <= 4'h0;
        end else if (!valid) begin
            sel_q <= 4'h0;
        end else begin
            unique case (rg_d)
                amd_pkg::rg_none:  sel_q <= 4'h0;
                amd_pkg::rg_hw:    sel_q <= 4'h1;
                amd_pkg::rg_ram:   sel_q <= 4'h2;
                amd_pkg::rg_eep:   sel_q <= 4'h4;
                amd_pkg::rg_flash: sel_q <= 4'h8;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            s0_hit_q    <= 1'b0;
            vec_q       <= 1'b0;
            stk_fault_q <= 1'b0;
        end else begin
            s0_hit_q    <= valid && !stk_bad && 17'(addr) >= amd_pkg::SPACE_TOP - s0_size;
            vec_q       <= valid && !stk_bad && addr >= amd_pkg::VEC_BASE;
            stk_fault_q <= valid && stk_bad;
        end
    end

endmodule : amd_decode
`default_nettype wire

// File: hw/amd_top.sv
// memory map decoder with port and small timer registers on AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module amd_top (
    input  wire logic        clk,
    input  wire logic        nrst,
    // axi4-lite slave
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // processor access port
    input  wire logic        cpu_valid,
    input  wire logic [15:0] cpu_addr,
    input  wire logic        cpu_we,
    input  wire logic        cpu_stack,
    input  wire logic [7:0]  cpu_wdata,
    output logic [7:0]       cpu_rdata,
    // region selects
    output logic             sel_hw,
    output logic             sel_ram,
    output logic             sel_eep,
    output logic             sel_flash,
    output logic             flash_sector0,
    output logic             vector_fetch,
    output logic             stack_fault,
    output logic [15:0]      sector0_base,
    // option byte and timer state
    input  wire logic [1:0]  opt_sector0_code,
    input  wire logic [7:0]  tmr_count,
    input  wire logic [7:0]  tmr_capture,
    // register contents
    output logic [7:0]       port_a_data,
    output logic [7:0]       port_a_direction,
    output logic [7:0]       port_a_option,
    output logic [7:0]       port_b_data,
    output logic [7:0]       port_b_direction,
    output logic [7:0]       port_b_option,
    output logic [7:0]       small_timer_ctrl_status_two,
    output logic [7:0]       small_timer_reload,
    output logic [7:0]       small_timer_ctrl_status_one
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    amd_reg_if rb ();

    logic [3:0]  sel_w;
    logic [6:0]  aw_idx_q;
    logic        aw_ok_q;
    logic        aw_have_q;
    logic [7:0]  w_data_q;
    logic        w_lane_q;
    logic        w_have_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [7:0]  rdata_q;
    logic [7:0]  cpu_rdata_q;
    logic        cpu_hw;
    logic        cpu_wr;
    logic        axi_go;
    logic [6:0]  ar_idx;
    logic        ar_ok;

    // a slot answers only when implemented and not in the gap
    function automatic logic slot_hit(input logic [6:0] i);
        slot_hit = (i[6:4] == 3'h0) && amd_pkg::HIT_MASK[i[3:0]];
    endfunction : slot_hit

    // ------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------
    amd_decode u_dec (
        .clk         (clk),
        .nrst        (nrst),
        .valid       (cpu_valid),
        .addr        (cpu_addr),
        .stack       (cpu_stack),
        .s0_code     (opt_sector0_code),
        .sel_q       (sel_w),
        .s0_hit_q    (flash_sector0),
        .vec_q       (vector_fetch),
        .stk_fault_q (stack_fault),
        .s0_base_q   (sector0_base)
    );

    amd_regs u_regs (
        .clk         (clk),
        .nrst        (nrst),
        .rb          (rb.slave),
        .tmr_count   (tmr_count),
        .tmr_capture (tmr_capture)
    );

    assign sel_hw    = sel_w[0];
    assign sel_ram   = sel_w[1];
    assign sel_eep   = sel_w[2];
    assign sel_flash = sel_w[3];

    // register contents straight from the slot flops
    assign port_a_data                 = rb.view[amd_pkg::IDX_PA_DATA[3:0]];
    assign port_a_direction            = rb.view[amd_pkg::IDX_PA_DIR[3:0]];
    assign port_a_option               = rb.view[amd_pkg::IDX_PA_OPT[3:0]];
    assign port_b_data                 = rb.view[amd_pkg::IDX_PB_DATA[3:0]];
    assign port_b_direction            = rb.view[amd_pkg::IDX_PB_DIR[3:0]];
    assign port_b_option               = rb.view[amd_pkg::IDX_PB_OPT[3:0]];
    assign small_timer_ctrl_status_two = rb.view[amd_pkg::IDX_LT_CS2[3:0]];
    assign small_timer_reload          = rb.view[amd_pkg::IDX_LT_RLD[3:0]];
    assign small_timer_ctrl_status_one = rb.view[amd_pkg::IDX_LT_CS1[3:0]];

    // ------------------------------------------------------------
    // write port arbitration
    // ------------------------------------------------------------
    // processor wins; the bus write waits for as long as a processor write is on the port
    assign cpu_hw = cpu_valid && !cpu_stack && cpu_addr <= amd_pkg::HW_LAST;
    assign cpu_wr = cpu_hw && cpu_we;
    assign axi_go = aw_have_q && w_have_q && !bvalid_q && !cpu_wr;

    always_comb begin
        rb.wr    = 1'b0;
        rb.idx   = aw_idx_q;
        rb.wdata = w_data_q;
        if (cpu_wr) begin
            rb.wr    = 1'b1;
            rb.idx   = cpu_addr[6:0];
            rb.wdata = cpu_wdata;
        end else if (axi_go) begin
            rb.wr    = aw_ok_q && w_lane_q;
        end
    end

    // ------------------------------------------------------------
    // processor register reads
    // ------------------------------------------------------------
    // gap reads as zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            cpu_rdata_q <= 8'h00;
        end else if (cpu_hw && !cpu_we) begin
            cpu_rdata_q <= slot_hit(cpu_addr[6:0]) ? rb.view[cpu_addr[3:0]] : 8'h00;
        end
    end

    assign cpu_rdata = cpu_rdata_q;

    // ------------------------------------------------------------
    // axi write address and data capture
    // ------------------------------------------------------------
    // slot index is the byte address over four
    always_ff @(posedge clk) begin
        if (!nrst) begin
            aw_have_q <= 1'b0;
            aw_idx_q  <= 7'h00;
            aw_ok_q   <= 1'b0;
        end else if (s_axi_awvalid && !aw_have_q) begin
            aw_have_q <= 1'b1;
            aw_idx_q  <= s_axi_awaddr[8:2];
            aw_ok_q   <= (s_axi_awaddr[31:9] == 23'h000000) && slot_hit(s_axi_awaddr[8:2]);
        end else if (axi_go) begin
            aw_have_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            w_have_q <= 1'b0;
            w_data_q <= 8'h00;
            w_lane_q <= 1'b0;
        end else if (s_axi_wvalid && !w_have_q) begin
            w_have_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane_q <= s_axi_wstrb[0];
        end else if (axi_go) begin
            w_have_q <= 1'b0;
        end
    end

    assign s_axi_awready = !aw_have_q;
    assign s_axi_wready  = !w_have_q;

    // ------------------------------------------------------------
    // axi write response
    // ------------------------------------------------------------
    // unmapped and reserved slots answer slverr
    always_ff @(posedge clk) begin
        if (!nrst) begin
            bvalid_q <= 1'b0;
            bresp_q  <= amd_pkg::RESP_OKAY;
        end else if (axi_go) begin
            bvalid_q <= 1'b1;
            bresp_q  <= aw_ok_q ? amd_pkg::RESP_OKAY : amd_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // ------------------------------------------------------------
    // axi read
    // ------------------------------------------------------------
    assign ar_idx = s_axi_araddr[8:2];
    assign ar_ok  = (s_axi_araddr[31:9] == 23'h000000) && slot_hit(ar_idx);

    // one cycle from address to data; upper bits read zero
    always_ff @(posedge clk) begin
        if (!nrst) begin
            rvalid_q <= 1'b0;
            rresp_q  <= amd_pkg::RESP_OKAY;
            rdata_q  <= 8'h00;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rresp_q  <= ar_ok ? amd_pkg::RESP_OKAY : amd_pkg::RESP_SLVERR;
            rdata_q  <= ar_ok ? rb.view[ar_idx[3:0]] : 8'h00;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = {24'h000000, rdata_q};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    property p_onehot;
        $onehot0({sel_hw, sel_ram, sel_eep, sel_flash});
    endproperty
    a_onehot: assert property (p_onehot)
        else $error("more than one region selected");

    property p_top;
        cpu_valid && !cpu_stack && cpu_addr >= amd_pkg::FL_BASE
            |=> sel_flash && !sel_hw && !sel_ram && !sel_eep;
    endproperty
    a_top: assert property (p_top)
        else $error("top of space not decoded to flash");

    property p_hw;
        cpu_valid && !cpu_stack && cpu_addr <= amd_pkg::HW_LAST
            && cpu_addr[6:0] != amd_pkg::IDX_RSV0 && cpu_addr[6:0] != amd_pkg::IDX_RSV1
            |=> sel_hw && !sel_ram;
    endproperty
    a_hw: assert property (p_hw)
        else $error("register area not selected");

    property p_ram;
        cpu_valid && !cpu_stack && cpu_addr >= amd_pkg::RAM_BASE
            && cpu_addr <= amd_pkg::RAM_LAST |=> sel_ram && !sel_hw && !stack_fault;
    endproperty
    a_ram: assert property (p_ram)
        else $error("ram area not selected");

    property p_eep;
        cpu_valid && !cpu_stack && cpu_addr >= amd_pkg::EEP_BASE
            && cpu_addr <= amd_pkg::EEP_LAST |=> sel_eep ##1 !sel_eep || $past(cpu_valid);
    endproperty
    a_eep: assert property (p_eep)
        else $error("eeprom area not selected");

    property p_stk;
        cpu_valid && cpu_stack
            && (cpu_addr < amd_pkg::STK_BASE || cpu_addr > amd_pkg::STK_LAST)
            |=> stack_fault && !sel_ram && !sel_hw;
    endproperty
    a_stk: assert property (p_stk)
        else $error("stack access outside window not refused");

    property p_vec;
        cpu_valid && !cpu_stack && cpu_addr >= amd_pkg::VEC_BASE
            |=> vector_fetch && sel_flash && flash_sector0;
    endproperty
    a_vec: assert property (p_vec)
        else $error("vector fetch not in flash sector 0");

    property p_s0;
        cpu_valid && !cpu_stack && $past(nrst) && cpu_addr >= sector0_base
            && $stable(sector0_base) |=> flash_sector0;
    endproperty
    a_s0: assert property (p_s0)
        else $error("sector 0 address not flagged");

    property p_opt;
        $past(nrst) && $past(nrst, 2) && $past(nrst, 3) |-> $stable(sector0_base);
    endproperty
    a_opt: assert property (p_opt)
        else $error("sector 0 size moved after capture");

    property p_rsv;
        s_axi_arvalid && s_axi_arready && s_axi_araddr[31:9] == 23'h000000
            && (ar_idx == amd_pkg::IDX_RSV0 || ar_idx == amd_pkg::IDX_RSV1)
            |=> s_axi_rvalid && s_axi_rresp == amd_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
    endproperty
    a_rsv: assert property (p_rsv)
        else $error("reserved gap read not refused");

    property p_gap_sel;
        cpu_valid && !cpu_stack
            && (cpu_addr == 16'(amd_pkg::IDX_RSV0) || cpu_addr == 16'(amd_pkg::IDX_RSV1))
            |=> !sel_hw && !sel_ram && !sel_eep && !sel_flash;
    endproperty
    a_gap_sel: assert property (p_gap_sel)
        else $error("reserved gap raised a select");

    property p_gap_rd;
        cpu_valid && !cpu_stack && !cpu_we
            && (cpu_addr == 16'(amd_pkg::IDX_RSV0) || cpu_addr == 16'(amd_pkg::IDX_RSV1))
            |=> cpu_rdata == 8'h00;
    endproperty
    a_gap_rd: assert property (p_gap_rd)
        else $error("reserved gap read not zero");

endmodule : amd_top
`default_nettype wire

// File: testbench/amd_cpu_model.sv
// processor core model issuing single-cycle memory and register accesses
`timescale 1ns/1ps
`default_nettype none
module amd_cpu_model (
    input  wire logic   clk,
    output logic        cpu_valid,
    output logic [15:0] cpu_addr,
    output logic        cpu_we,
    output logic        cpu_stack,
    output logic [7:0]  cpu_wdata
);
    // ----------------------------------------
    // idle state
    // ----------------------------------------
    initial begin
        cpu_valid = 1'b0;
        cpu_addr  = 16'h0000;
        cpu_we    = 1'b0;
        cpu_stack = 1'b0;
        cpu_wdata = 8'h00;
    end

    // reserved only on request
    // one strobe cycle; valid drops, address, write and data lines flip, stack holds, so a stale address never decodes
    task automatic access(input logic [15:0] a, input logic w, input logic s,
                          input logic [7:0] d);
        @(posedge clk);
        cpu_valid <= 1'b1;
        cpu_addr  <= a;
        cpu_we    <= w;
        cpu_stack <= s;
        cpu_wdata <= d;
        @(posedge clk);
        cpu_valid <= 1'b0;
        cpu_addr  <= ~a;
        cpu_we    <= ~w;
        cpu_wdata <= ~d;
        #1;
    endtask : access
endmodule : amd_cpu_model
`default_nettype wire

// File: testbench/amd_top_tb.sv
// self-checking bench: axi4-lite register access and cpu address decode
`timescale 1ns/1ps
`default_nettype none
module amd_top_tb;
    logic clk, nrst, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [31:0] awa, wd, ara, rd;
    logic [3:0] ws;
    logic [1:0] bresp, rresp, code;
    logic cv, cwe, cst;
    logic [15:0] ca, s0b;
    logic [7:0] cwd, crd, tcnt, tcap;
    logic [7:0] pad, padir, paopt, pbd, pbdir, pbopt, lcs2, lrld, lcs1;
    logic shw, sram, seep, sfl, fs0, vf, sf;
    logic [31:0] rdv;
    logic [1:0] rsp;
    int miscompares, compares;
    localparam logic [15:0] DA[15] = '{16'h0000, 16'h007F, 16'h0006, 16'h0080, 16'h01FF,
        16'h0200, 16'h1000, 16'h10FF, 16'h1100, 16'hDFFF, 16'hE000, 16'hEFFF, 16'hF000,
        16'hFFE0, 16'hFFFF};
    localparam logic [6:0] DE[15] = '{7'h40, 7'h40, 7'h00, 7'h20, 7'h20, 7'h00, 7'h10,
        7'h10, 7'h00, 7'h00, 7'h08, 7'h08, 7'h0C, 7'h0E, 7'h0E};
    localparam logic [7:0] RV[13] = '{8'hFF, 8'h00, 8'h40, 8'hFF, 8'h00, 8'h00, 8'h00,
        8'h00, 8'h00, 8'h00, 8'h5A, 8'h00, 8'hA5};

    amd_cpu_model i_amd_cpu_model (.clk(clk), .cpu_valid(cv), .cpu_addr(ca), .cpu_we(cwe),
        .cpu_stack(cst), .cpu_wdata(cwd));
    amd_top i_amd_top (.clk(clk), .nrst(nrst), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
        .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .cpu_valid(cv),
        .cpu_addr(ca), .cpu_we(cwe), .cpu_stack(cst), .cpu_wdata(cwd), .cpu_rdata(crd),
        .sel_hw(shw), .sel_ram(sram), .sel_eep(seep), .sel_flash(sfl),
        .flash_sector0(fs0), .vector_fetch(vf), .stack_fault(sf), .sector0_base(s0b),
        .opt_sector0_code(code), .tmr_count(tcnt), .tmr_capture(tcap),
        .port_a_data(pad), .port_a_direction(padir), .port_a_option(paopt),
        .port_b_data(pbd), .port_b_direction(pbdir), .port_b_option(pbopt),
        .small_timer_ctrl_status_two(lcs2), .small_timer_reload(lrld),
        .small_timer_ctrl_status_one(lcs1));

    // ----------------------------------------
    // clock, watchdog, shared tasks
    // ----------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // whole run is about 130 cycles; this margin only catches a hang
    initial begin
        #100000;
        miscompares++;
        final_report();
    end
    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", n, exp, seen);
        end
    endtask : chk
    task automatic do_reset(input logic [1:0] c);
        nrst <= 1'b0;
        code <= c;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset
    task automatic axw(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge clk);
        awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; br <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wr) wv <= 1'b0;
            if (bv) begin r = bresp; done = 1; br <= 1'b0; end
        end
    endtask : axw
    task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        @(posedge clk);
        ara <= a; arv <= 1'b1; rr <= 1'b1;
        while (!done) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) begin d = rd; r = rresp; done = 1; rr <= 1'b0; end
        end
    endtask : axr
    task automatic dec(input logic [15:0] a, input logic s, input logic [6:0] e);
        i_amd_cpu_model.access(a, 1'b0, s, 8'h00);
        chk("selects", {shw, sram, seep, sfl, fs0, vf, sf}, e);
    endtask : dec
    task automatic final_report();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : final_report

    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        {awv, wv, br, arv, rr} = '0;
        awa = '0; wd = '0; ws = 4'hF; ara = '0;
        tcnt = 8'h5A; tcap = 8'hA5; nrst = 1'b0; code = 2'h3;
        do_reset(2'h3);
        chk("port a outputs", {pad, padir, paopt, pbd}, 32'hFF0040FF);
        chk("port b timer outputs", {pbdir, pbopt, lcs2, lrld}, 32'h0);
        chk("timer status one", lcs1, 8'h00);
        chk("cpu_rdata", crd, 8'h00);
        for (int i = 0; i < 13; i++) begin
            axr(i * 4, rdv, rsp);
            chk("reset value", rdv, {24'h0, RV[i]});
            chk("read resp", rsp, (i == 6 || i == 7) ? 2'h2 : 2'h0);
        end
        axr(32'h34, rdv, rsp);
        chk("unmapped resp", rsp, 2'h2);
        $display("test reset values done");
        axw(32'h04, 32'h5A, rsp);
        chk("write resp", rsp, 2'h0);
        chk("port_a_direction", padir, 8'h5A);
        axw(32'h28, 32'h11, rsp);
        axr(32'h28, rdv, rsp);
        chk("read only slot", rdv, 32'h5A);
        ws <= 4'hE;
        axw(32'h24, 32'h77, rsp);
        chk("masked write resp", rsp, 2'h0);
        chk("masked write", lrld, 8'h00);
        ws <= 4'hF;
        axw(32'h18, 32'h33, rsp);
        chk("reserved write", rsp, 2'h2);
        axw(32'h200, 32'h33, rsp);
        chk("upper bits write", rsp, 2'h2);
        $display("test axi access done");
        i_amd_cpu_model.access(16'h0008, 1'b1, 1'b0, 8'h3C);
        chk("cpu register write", lcs2, 8'h3C);
        i_amd_cpu_model.access(16'h0008, 1'b0, 1'b0, 8'h00);
        chk("cpu read", crd, 8'h3C);
        i_amd_cpu_model.access(16'h0006, 1'b0, 1'b0, 8'h00);
        chk("cpu reserved read", crd, 8'h00);
        $display("test cpu registers done");
        chk("sector0 base", s0b, 16'hF000);
        for (int i = 0; i < 15; i++) dec(DA[i], 1'b0, DE[i]);
        dec(16'h0180, 1'b1, 7'h20);
        dec(16'h01FF, 1'b1, 7'h20);
        dec(16'h017F, 1'b1, 7'h01);
        $display("test decode done");
        do_reset(2'h2);
        chk("sector0 base", s0b, 16'hF800);
        dec(16'hF7FF, 1'b0, 7'h08);
        dec(16'hF800, 1'b0, 7'h0C);
        $display("test option code done");
        final_report();
    end
endmodule : amd_top_tb
`default_nettype wire
